// ### cps_pkg.sv
// shared constants and types of the program sequencer
package cps_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int IP_W    = 14;
  localparam int LO_W    = 8;
  localparam int HI_W    = 6;
  localparam int DATA_W  = 8;
  localparam int RAM_AW  = 8;
  localparam int RAM_DEP = 256;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and steps
  localparam logic [IP_W-1:0]   IP_RESET  = 14'h0000;
  localparam logic [DATA_W-1:0] SP_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] IDX_RESET = 8'h00;
  localparam logic [DATA_W-1:0] SP_STEP   = 8'h01;
  localparam logic [DATA_W-1:0] SP_PAIR   = 8'h02;
  localparam logic [HI_W-1:0]   PAGE_STEP = 6'h01;
  localparam logic [DATA_W-1:0] NO_OFFSET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // second saved byte layout: carry, zero, upper pointer bits
  localparam int B1_CARRY = 7;
  localparam int B1_ZERO  = 6;
  localparam int B1_HI_TOP = 5;

  ////////////////////////////////////////////////////////////////////////////
  // operations presented by instruction fetch and decode
  typedef enum logic [3:0] {
    CPS_NONE_OP,
    CPS_STEP_OP,
    CPS_PAGE_ADVANCE_OP,
    CPS_CALL_OP,
    CPS_SUBROUTINE_RETURN_OP,
    CPS_INTERRUPT_RETURN_OP,
    CPS_LOAD_STACK_PTR_OP,
    CPS_MOV_A_OP,
    CPS_MOV_X_OP,
    CPS_ALU_OP,
    CPS_READ_A_OP,
    CPS_WRITE_A_OP,
    CPS_DISABLE_INT_OP,
    CPS_ENABLE_INT_OP
  } cps_op_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PUSH2,
    ST_POP1,
    ST_POP2,
    ST_POP3,
    ST_LOAD
  } cps_state_t;

  typedef struct packed {
    cps_op_t           op;
    logic [1:0]        len;      // instruction length in bytes
    logic [DATA_W-1:0] operand;  // constant or base address
    logic              indexed;  // add index register to operand
    logic [IP_W-1:0]   target;   // call destination
    logic [DATA_W-1:0] alu_res;
    logic              alu_carry;
    logic              alu_zero;
  } cps_cmd_t;

  typedef struct packed {
    logic [IP_W-1:0]   ip;
    logic [DATA_W-1:0] sp;
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] idx;
    logic              carry;
    logic              zero;
    logic              int_en;
  } cps_status_t;

endpackage

// ### cps_ram.sv
// data ram holding the return stack and variables, registered read
`timescale 1ns/1ps
`default_nettype none
module cps_ram
  import cps_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic              we,
  input  wire logic [RAM_AW-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  output var  logic [DATA_W-1:0] rdata_q
);

  logic [DATA_W-1:0] mem [RAM_DEP];

  // storage array, no reset
  always_ff @(posedge clk_sys)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
  end

  // read data registered, one cycle after address
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_q <= ACC_RESET;
    end
    else
    begin
      rdata_q <= mem[addr];
    end
  end

endmodule
`default_nettype wire

// ### cps_stack_pack.sv
// packs and unpacks pointer and flags into two stack bytes
`timescale 1ns/1ps
`default_nettype none
module cps_stack_pack
  import cps_pkg::*;
(
  input  wire logic [IP_W-1:0]   ip_in,
  input  wire logic              carry_in,
  input  wire logic              zero_in,
  output var  logic [DATA_W-1:0] byte0,
  output var  logic [DATA_W-1:0] byte1,
  input  wire logic [DATA_W-1:0] byte0_in,
  input  wire logic [DATA_W-1:0] byte1_in,
  output var  logic [IP_W-1:0]   ip_out,
  output var  logic              carry_out,
  output var  logic              zero_out
);

  // first byte low pointer bits, second flags and page
  assign byte0     = ip_in[LO_W-1:0];
  assign byte1     = {carry_in, zero_in, ip_in[IP_W-1:LO_W]};
  assign ip_out    = {byte1_in[B1_HI_TOP:0], byte0_in};
  assign carry_out = byte1_in[B1_CARRY];
  assign zero_out  = byte1_in[B1_ZERO];

endmodule
`default_nettype wire

// ### cps_sequencer.sv
// program sequencer: pointer, return stack, accumulator, index register
// Operation
// - pointer is 14 bits, reset to 0x0000.
// - sequential execution advances only the low eight pointer bits.
// - page advance increments the upper six pointer bits.
// - interrupt and call save next pointer and flags as two bytes.
// - only interrupt return reloads carry and zero from the stack.
// - pointer not an operand; stack readable as data ram from 0x00.
// - reset clears stack pointer; stack grows upward from 0x00.
// - load stack pointer copies the accumulator into it.
// - interrupt acknowledge disables further interrupts.
// - push writes at pointer, increments, writes, increments again.
// - interrupt return pops second byte then first, decrementing before each.
// - interrupt return re-enables interrupts in the same cycle as restoring.
// - call pushes two bytes, stack pointer up by two.
// - subroutine return reloads pointer only, stack pointer down by two.
// - index register is auxiliary accumulator and indexed offset.
// - accumulator receives arithmetic and logic results.
`timescale 1ns/1ps
`default_nettype none
module cps_sequencer
  import cps_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                resetn,
  input  wire logic                cmd_valid,
  input  wire cps_pkg::cps_cmd_t   cmd,
  input  wire logic                irq_req,
  input  wire logic [cps_pkg::IP_W-1:0] irq_vector,
  output var  logic                cmd_ready_q,
  output var  logic                cmd_ack_q,
  output var  logic                irq_ack_q,
  output var  cps_pkg::cps_status_t status_q
);
  import cps_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  cps_state_t        state_q,  state_d;
  logic [IP_W-1:0]   ip_q,     ip_d;
  logic [DATA_W-1:0] sp_q,     sp_d;
  logic [DATA_W-1:0] acc_q,    acc_d;
  logic [DATA_W-1:0] idx_q,    idx_d;
  logic              carry_q,  carry_d;
  logic              zero_q,   zero_d;
  logic              ie_q,     ie_d;
  logic              interrupt_return_op_q,   interrupt_return_op_d;
  logic [IP_W-1:0]   dest_q,   dest_d;
  logic [DATA_W-1:0] hold_q,   hold_d;
  logic [DATA_W-1:0] b1_q,     b1_d;

  ////////////////////////////////////////////////////////////////////////////
  // acceptance decode
  wire logic idle      = (state_q == ST_IDLE);
  wire logic take_irq  = idle && irq_req && ie_q;
  wire logic take_cmd  = idle && cmd_valid && !take_irq;
  wire logic op_step   = take_cmd && (cmd.op == CPS_STEP_OP);
  wire logic op_page   = take_cmd && (cmd.op == CPS_PAGE_ADVANCE_OP);
  wire logic op_call   = take_cmd && (cmd.op == CPS_CALL_OP);
  wire logic op_ret    = take_cmd && (cmd.op == CPS_SUBROUTINE_RETURN_OP);
  wire logic op_interrupt_return_op   = take_cmd && (cmd.op == CPS_INTERRUPT_RETURN_OP);
  wire logic op_ldsp   = take_cmd && (cmd.op == CPS_LOAD_STACK_PTR_OP);
  wire logic op_mova   = take_cmd && (cmd.op == CPS_MOV_A_OP);
  wire logic op_movx   = take_cmd && (cmd.op == CPS_MOV_X_OP);
  wire logic op_alu    = take_cmd && (cmd.op == CPS_ALU_OP);
  wire logic op_rda    = take_cmd && (cmd.op == CPS_READ_A_OP);
  wire logic op_wra    = take_cmd && (cmd.op == CPS_WRITE_A_OP);
  wire logic op_di     = take_cmd && (cmd.op == CPS_DISABLE_INT_OP);
  wire logic op_ei     = take_cmd && (cmd.op == CPS_ENABLE_INT_OP);

  ////////////////////////////////////////////////////////////////////////////
  // pointer arithmetic
  wire logic [LO_W-1:0] len_ext = {6'h00, cmd.len};
  wire logic [LO_W-1:0] lo_next = ip_q[LO_W-1:0] + len_ext;
  wire logic [IP_W-1:0] ip_seq  = {ip_q[IP_W-1:LO_W], lo_next};
  wire logic [HI_W-1:0] hi_next = ip_q[IP_W-1:LO_W] + PAGE_STEP;
  wire logic [IP_W-1:0] ip_page = {hi_next, ip_q[LO_W-1:0]};
  wire logic [DATA_W-1:0] sp_inc = sp_q + SP_STEP;
  wire logic [DATA_W-1:0] sp_dec = sp_q - SP_STEP;

  // indexed operand address
  wire logic [DATA_W-1:0] offset   = cmd.indexed ? idx_q : NO_OFFSET;
  wire logic [DATA_W-1:0] data_adr = cmd.operand + offset;

  ////////////////////////////////////////////////////////////////////////////
  // stack byte packing
  wire logic [IP_W-1:0] save_ip = take_irq ? ip_q : ip_seq;
  logic [DATA_W-1:0] pk_b0;
  logic [DATA_W-1:0] pk_b1;
  logic [IP_W-1:0]   rs_ip;
  logic              rs_carry;
  logic              rs_zero;
  logic [DATA_W-1:0] ram_rdata;

  cps_stack_pack u_pack (
    .ip_in     (save_ip),
    .carry_in  (carry_q),
    .zero_in   (zero_q),
    .byte0     (pk_b0),
    .byte1     (pk_b1),
    .byte0_in  (ram_rdata),
    .byte1_in  (b1_q),
    .ip_out    (rs_ip),
    .carry_out (rs_carry),
    .zero_out  (rs_zero)
  );

  ////////////////////////////////////////////////////////////////////////////
  // data ram port select
  wire logic push_a = take_irq || op_call;
  wire logic push_b = (state_q == ST_PUSH2);
  wire logic ram_we = push_a || push_b || op_wra;
  wire logic [RAM_AW-1:0] ram_addr =
    (push_a || push_b || !idle) ? sp_q : data_adr;
  wire logic [DATA_W-1:0] ram_wdata =
    push_a ? pk_b0 : (push_b ? hold_q : acc_q);

  cps_ram u_ram (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .we      (ram_we),
    .addr    (ram_addr),
    .wdata   (ram_wdata),
    .rdata_q (ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    state_d = state_q;
    ip_d    = ip_q;
    sp_d    = sp_q;
    acc_d   = acc_q;
    idx_d   = idx_q;
    carry_d = carry_q;
    zero_d  = zero_q;
    ie_d    = ie_q;
    interrupt_return_op_d  = interrupt_return_op_q;
    dest_d  = dest_q;
    hold_d  = hold_q;
    b1_d    = b1_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (push_a)
        begin
          sp_d    = sp_inc;
          hold_d  = pk_b1;
          dest_d  = take_irq ? irq_vector : cmd.target;
          state_d = ST_PUSH2;
          if (take_irq)
          begin
            ie_d = 1'b0;
          end
        end
        if (op_ret || op_interrupt_return_op)
        begin
          sp_d    = sp_dec;
          interrupt_return_op_d  = op_interrupt_return_op;
          state_d = ST_POP1;
        end
        if (op_step)
        begin
          ip_d = ip_seq;
        end
        if (op_page)
        begin
          ip_d = ip_page;
        end
        if (op_ldsp)
        begin
          sp_d = acc_q;
        end
        if (op_mova)
        begin
          acc_d = cmd.operand;
        end
        if (op_movx)
        begin
          idx_d = cmd.operand;
        end
        if (op_alu)
        begin
          acc_d   = cmd.alu_res;
          carry_d = cmd.alu_carry;
          zero_d  = cmd.alu_zero;
        end
        if (op_rda)
        begin
          state_d = ST_LOAD;
        end
        if (op_di)
        begin
          ie_d = 1'b0;
        end
        if (op_ei)
        begin
          ie_d = 1'b1;
        end
      end
      ST_PUSH2:
      begin
        sp_d    = sp_inc;
        ip_d    = dest_q;
        state_d = ST_IDLE;
      end
      ST_POP1:
      begin
        sp_d    = sp_dec;
        state_d = ST_POP2;
      end
      ST_POP2:
      begin
        b1_d    = ram_rdata;
        state_d = ST_POP3;
      end
      ST_POP3:
      begin
        ip_d    = rs_ip;
        state_d = ST_IDLE;
        if (interrupt_return_op_q)
        begin
          carry_d = rs_carry;
          zero_d  = rs_zero;
          ie_d    = 1'b1;
        end
      end
      ST_LOAD:
      begin
        acc_d   = ram_rdata;
        state_d = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ST_IDLE;
      ip_q    <= IP_RESET;
      sp_q    <= SP_RESET;
      acc_q   <= ACC_RESET;
      idx_q   <= IDX_RESET;
      carry_q <= 1'b0;
      zero_q  <= 1'b0;
      ie_q    <= 1'b0;
      interrupt_return_op_q  <= 1'b0;
      dest_q  <= IP_RESET;
      hold_q  <= ACC_RESET;
      b1_q    <= ACC_RESET;
    end
    else
    begin
      state_q <= state_d;
      ip_q    <= ip_d;
      sp_q    <= sp_d;
      acc_q   <= acc_d;
      idx_q   <= idx_d;
      carry_q <= carry_d;
      zero_q  <= zero_d;
      ie_q    <= ie_d;
      interrupt_return_op_q  <= interrupt_return_op_d;
      dest_q  <= dest_d;
      hold_q  <= hold_d;
      b1_q    <= b1_d;
    end
  end

  // handshake outputs
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      cmd_ready_q <= 1'b1;
      cmd_ack_q   <= 1'b0;
      irq_ack_q   <= 1'b0;
    end
    else
    begin
      cmd_ready_q <= (state_d == ST_IDLE);
      cmd_ack_q   <= take_cmd;
      irq_ack_q   <= take_irq;
    end
  end

  // status view built from flops only
  assign status_q = '{ip: ip_q, sp: sp_q, acc: acc_q, idx: idx_q,
                      carry: carry_q, zero: zero_q, int_en: ie_q};

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_push_first;
    ram_we && (ram_addr == sp_q) && (ram_wdata == pk_b0);
  endsequence
  sequence s_push_second;
    ram_we && (ram_addr == $past(sp_q) + SP_STEP);
  endsequence

  property p_push_order;
    @(posedge clk_sys) disable iff (!resetn)
      push_a |-> s_push_first ##1 s_push_second;
  endproperty
  a_push_order: assert property (p_push_order)
    else $error("push bytes not at pointer then pointer plus one");

  property p_call_sp;
    @(posedge clk_sys) disable iff (!resetn)
      op_call |-> ##2 (sp_q == $past(sp_q, 2) + SP_PAIR) && (ip_q == $past(dest_d, 1));
  endproperty
  a_call_sp: assert property (p_call_sp)
    else $error("call did not raise stack pointer by two");

  property p_ret_keeps_flags;
    @(posedge clk_sys) disable iff (!resetn)
      op_ret |-> ##4 (sp_q == $past(sp_q, 4) - SP_PAIR)
                 && (carry_q == $past(carry_q, 4)) && (zero_q == $past(zero_q, 4));
  endproperty
  a_ret_keeps_flags: assert property (p_ret_keeps_flags)
    else $error("subroutine return wrong pointer or changed flags");

  sequence s_pop_addr;
    (state_q == ST_POP1) ##1 (ram_addr == $past(ram_addr) - SP_STEP);
  endsequence
  property p_pop_order;
    @(posedge clk_sys) disable iff (!resetn)
      op_interrupt_return_op |-> ##1 s_pop_addr ##2 (ie_q && state_q == ST_IDLE);
  endproperty
  a_pop_order: assert property (p_pop_order)
    else $error("interrupt return pop order or timing wrong");

  property p_interrupt_return_op_enables;
    @(posedge clk_sys) disable iff (!resetn)
      op_interrupt_return_op |-> (ie_d == ie_q) [*3] ##1 (ie_d && (state_q == ST_POP3));
  endproperty
  a_interrupt_return_op_enables: assert property (p_interrupt_return_op_enables)
    else $error("interrupt return did not enable interrupts");

  property p_irq_disables;
    @(posedge clk_sys) disable iff (!resetn)
      take_irq |=> !ie_q && irq_ack_q ##1 (ip_q == $past(irq_vector, 2));
  endproperty
  a_irq_disables: assert property (p_irq_disables)
    else $error("interrupt acknowledge left interrupts enabled");

  property p_step_wraps;
    @(posedge clk_sys) disable iff (!resetn)
      op_step |=> (ip_q[IP_W-1:LO_W] == $past(ip_q[IP_W-1:LO_W]))
               && (ip_q[LO_W-1:0] == $past(ip_q[LO_W-1:0]) + $past(cmd.len));
  endproperty
  a_step_wraps: assert property (p_step_wraps)
    else $error("sequential step changed the page");

  property p_page_adv;
    @(posedge clk_sys) disable iff (!resetn)
      op_page |=> (ip_q[IP_W-1:LO_W] == $past(ip_q[IP_W-1:LO_W]) + PAGE_STEP)
               && (ip_q[LO_W-1:0] == $past(ip_q[LO_W-1:0]));
  endproperty
  a_page_adv: assert property (p_page_adv)
    else $error("page advance did not step upper bits");

  property p_flags_source;
    @(posedge clk_sys) disable iff (!resetn)
      ($changed(carry_q) || $changed(zero_q))
        |-> $past(op_alu) || ($past(state_q) == ST_POP3 && $past(interrupt_return_op_q));
  endproperty
  a_flags_source: assert property (p_flags_source)
    else $error("flags changed outside alu or interrupt return");

  property p_ldsp;
    @(posedge clk_sys) disable iff (!resetn)
      op_ldsp |=> (sp_q == $past(acc_q)) && cmd_ack_q;
  endproperty
  a_ldsp: assert property (p_ldsp)
    else $error("stack pointer not loaded from accumulator");

endmodule
`default_nettype wire

// ### cps_fetch_model.sv
// fetch and decode stand-in that hands commands and interrupts to the core
`timescale 1ns/1ps
`default_nettype none
module cps_fetch_model
  import cps_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     cmd_ready_q,
  input  wire logic                     cmd_ack_q,
  input  wire logic                     irq_ack_q,
  output var  logic                     cmd_valid,
  output var  cps_pkg::cps_cmd_t        cmd,
  output var  logic                     irq_req,
  output var  logic [cps_pkg::IP_W-1:0] irq_vector
);
  int stuck;

  ////////////////////////////////////////////////////////////////////////////
  // idle levels at time zero
  initial
  begin
    cmd_valid  = 1'b0;
    cmd        = '0;
    irq_req    = 1'b0;
    irq_vector = '0;
    stuck      = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // waits for the core to go idle, one edge more so results have landed
  task automatic wait_idle();
    int n;
    n = 0;
    while (cmd_ready_q !== 1'b1 && n < 50)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 50)
      stuck++;
    @(posedge clk_sys);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // presents one command, holds it until the ack, then scrambles the bus
  task automatic issue(input cps_cmd_t c);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd       = c;
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    while (cmd_ack_q !== 1'b1 && n < 50);
    if (n >= 50)
      stuck++;
    cmd_valid = 1'b0;
    cmd       = ~c; // released bus never keeps the last value
    wait_idle();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // raises an interrupt with its vector and holds it until acknowledged
  task automatic raise_irq(input logic [IP_W-1:0] vec);
    int n;
    n = 0;
    irq_req    = 1'b1;
    irq_vector = vec;
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    while (irq_ack_q !== 1'b1 && n < 50);
    if (n >= 50)
      stuck++;
    irq_req    = 1'b0;
    irq_vector = ~vec;
  endtask
endmodule
`default_nettype wire

// ### cpu_program_sequencer_bench.sv
// self-checking bench of the program sequencer
`timescale 1ns/1ps
`default_nettype none
module cpu_program_sequencer_bench;
  import cps_pkg::*;

  logic                 clk_sys;
  logic                 resetn;
  logic                 cmd_valid;
  cps_cmd_t             cmd;
  logic                 irq_req;
  logic [IP_W-1:0]      irq_vector;
  logic                 cmd_ready_q;
  logic                 cmd_ack_q;
  logic                 irq_ack_q;
  cps_status_t          st;
  int                   error_cnt;
  int                   tests_run;
  int                   cyc;

  ////////////////////////////////////////////////////////////////////////////
  // design and command source
  cps_sequencer DUT (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .cmd_valid   (cmd_valid),
    .cmd         (cmd),
    .irq_req     (irq_req),
    .irq_vector  (irq_vector),
    .cmd_ready_q (cmd_ready_q),
    .cmd_ack_q   (cmd_ack_q),
    .irq_ack_q   (irq_ack_q),
    .status_q    (st)
  );

  cps_fetch_model fm (
    .clk_sys     (clk_sys),
    .cmd_ready_q (cmd_ready_q),
    .cmd_ack_q   (cmd_ack_q),
    .irq_ack_q   (irq_ack_q),
    .cmd_valid   (cmd_valid),
    .cmd         (cmd),
    .irq_req     (irq_req),
    .irq_vector  (irq_vector)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 250 MHz clock and hang guard
  initial
  begin
    clk_sys = 1'b0;
    forever
      #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparison, command builder, verdict
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  function automatic cps_cmd_t mk(cps_op_t op, logic [7:0] opd = 8'h00,
                                  logic [13:0] tgt = 14'h0000,
                                  logic [1:0] ln = 2'h1, logic ix = 1'b0,
                                  logic [7:0] r = 8'h00,
                                  logic cy = 1'b0, logic zr = 1'b0);
    cps_cmd_t c;
    c = '{op, ln, opd, ix, tgt, r, cy, zr};
    return c;
  endfunction

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // reset held 8 cycles, then register state checked
  task automatic t_reset();
    resetn = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    chk(st.ip, 16'h0000);
    chk(st.sp, 16'h0000);
    chk({st.acc, st.idx}, 16'h0000);
    chk({st.int_en, cmd_ready_q}, 16'h0001);
  endtask

  // low byte wraps inside the page, page advance moves up one page
  task automatic t_page();
    fm.issue(mk(CPS_CALL_OP, 8'h00, 14'h01FE));
    fm.issue(mk(CPS_STEP_OP, 8'h00, 14'h0000, 2'h2));
    chk(st.ip, 16'h0100);
    fm.issue(mk(CPS_STEP_OP, 8'h00, 14'h0000, 2'h1));
    chk(st.ip, 16'h0101);
    fm.issue(mk(CPS_PAGE_ADVANCE_OP));
    chk(st.ip, 16'h0201);
    fm.issue(mk(CPS_MOV_A_OP, 8'h00));
    fm.issue(mk(CPS_LOAD_STACK_PTR_OP));
    chk(st.sp, 16'h0000);
  endtask

  // call saves two bytes from 0x00, return keeps the live flags
  task automatic t_call_ret();
    fm.issue(mk(CPS_ALU_OP, 8'h00, 14'h0000, 2'h1, 1'b0, 8'h5A, 1'b1));
    chk({st.acc, 6'h00, st.carry, st.zero}, 16'h5A02);
    fm.issue(mk(CPS_CALL_OP, 8'h00, 14'h1234));
    chk(st.ip, 16'h1234);
    chk(st.sp, 16'h0002);
    fm.issue(mk(CPS_READ_A_OP, 8'h00));
    chk(st.acc, 16'h0002);
    fm.issue(mk(CPS_READ_A_OP, 8'h01));
    chk(st.acc, 16'h0082);
    fm.issue(mk(CPS_ALU_OP, 8'h00, 14'h0000, 2'h1, 1'b0, 8'h00, 1'b0,
                1'b1));
    fm.issue(mk(CPS_SUBROUTINE_RETURN_OP));
    chk(st.ip, 16'h0202);
    chk({st.carry, st.zero}, 16'h0001);
    chk(st.sp, 16'h0000);
  endtask

  // index register adds to the operand base, wrapping at 8 bits
  task automatic t_indexed();
    fm.issue(mk(CPS_MOV_X_OP, 8'h03));
    chk(st.idx, 16'h0003);
    fm.issue(mk(CPS_READ_A_OP, 8'hFE, 14'h0000, 2'h1, 1'b1));
    chk(st.acc, 16'h0082);
    fm.issue(mk(CPS_MOV_A_OP, 8'hC3));
    fm.issue(mk(CPS_WRITE_A_OP, 8'h10, 14'h0000, 2'h1, 1'b1));
    fm.issue(mk(CPS_MOV_A_OP, 8'h00));
    fm.issue(mk(CPS_READ_A_OP, 8'h13));
    chk(st.acc, 16'h00C3);
  endtask

  // interrupt save, disable, and restore with flags on return
  task automatic t_irq();
    fm.issue(mk(CPS_ENABLE_INT_OP));
    fm.issue(mk(CPS_ALU_OP, 8'h00, 14'h0000, 2'h1, 1'b0, 8'h00, 1'b1,
                1'b1));
    fm.raise_irq(14'h0ABC);
    chk(st.int_en, 16'h0000);
    fm.wait_idle();
    chk(st.ip, 16'h0ABC);
    chk(st.sp, 16'h0002);
    fm.issue(mk(CPS_READ_A_OP, 8'h01));
    chk(st.acc, 16'h00C2);
    fm.issue(mk(CPS_READ_A_OP, 8'h00));
    chk(st.acc, 16'h0002);
    fm.issue(mk(CPS_ALU_OP));
    fm.issue(mk(CPS_INTERRUPT_RETURN_OP));
    chk(st.ip, 16'h0202);
    chk({st.carry, st.zero}, 16'h0003);
    chk({st.int_en, st.sp}, 16'h0100);
    fm.issue(mk(CPS_DISABLE_INT_OP));
    chk(st.int_en, 16'h0000);
  endtask

  // relocated stack, then a reset in mid-run
  task automatic t_relocate();
    fm.issue(mk(CPS_MOV_A_OP, 8'h40));
    fm.issue(mk(CPS_LOAD_STACK_PTR_OP));
    chk(st.sp, 16'h0040);
    fm.issue(mk(CPS_CALL_OP, 8'h00, 14'h0300, 2'h2));
    chk(st.sp, 16'h0042);
    fm.issue(mk(CPS_READ_A_OP, 8'h40));
    chk(st.acc, 16'h0004);
    t_reset();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    resetn    = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    cyc       = 0;
    t_reset();
    t_page();
    t_call_ret();
    t_indexed();
    t_irq();
    t_relocate();
    chk(16'(fm.stuck), 16'h0000);
    stop_test();
  end
endmodule
`default_nettype wire
